// ===== common/oam_pkg.sv
`default_nettype none
package oam_pkg;
    localparam int LOCAL_NODE_IDENTIFIER_W     = 32;
    localparam int BIP_W         = 16;
    localparam int CNT_W         = 16;
    localparam int SN_W          = 8;
    localparam int BLK_W         = 2;
    localparam int BLK_MIN_LOG2  = 7;
    localparam int ADDR_W        = 12;
    localparam logic [6:0] LB_UPPER_ZERO = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_CTRL    = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_LOCAL_NODE_IDENTIFIER = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_EXCL    = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 12'h00C;
    localparam logic [ADDR_W-1:0] ADDR_SEQ     = 12'h010;
    localparam logic [ADDR_W-1:0] ADDR_TUC     = 12'h014;
    localparam logic [ADDR_W-1:0] ADDR_BIP     = 12'h018;
    localparam logic [ADDR_W-1:0] ADDR_RX_CNT  = 12'h01C;
    localparam int CTRL_TR       = 0;
    localparam int CTRL_TERM     = 1;
    localparam int CTRL_E2E      = 2;
    localparam int CTRL_CLP      = 3;
    localparam int CTRL_BLK_LO   = 4;
    localparam int CTRL_GEN_EGR  = 6;
    localparam int ST_LATE       = 0;
    localparam int ST_OVF        = 1;
    localparam int ST_PEND       = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [LOCAL_NODE_IDENTIFIER_W-1:0] LOCAL_NODE_IDENTIFIER_RESET = 32'h0000_0000;
    localparam logic [LOCAL_NODE_IDENTIFIER_W-1:0] ALL_ONES_ID   = 32'hFFFF_FFFF;
endpackage : oam_pkg
`default_nettype wire

// ===== rtl/oam_loopback_and_block_monitor.sv
//Contract
// - Loopback indication: upper seven bits zero, LSB one before loopback, zero after.
// - Location ID compared to local_node_identifier; all-ones matches only when terminating.
// - Location match with indication one: remove cell and copy to extraction.
// - Ingress source ID match with indication zero: remove and copy.
// - Indication zero, all-ones source: copy everywhere, also remove at endpoint.
// - Indication zero cells removed at the endpoint regardless of identifiers.
// - Monitoring sequence number wraps modulo 256.
// - Transmitted total and CLP0 counts kept modulo 65536.
// - Block parity is even parity over user cell payloads since last monitor cell.
// - Block error result counts parity bits in error on received monitor cell.
// - Received total and CLP0 counts kept modulo 65536.
// - Bidirectional test: generate one direction, check the other.
// - First software-inserted monitor cell at origin sets test-running.
// - While running, count non-excluded cells, parity them, count CLP0 apart.
// - Clearing test-running stops counting and monitor cell generation.
// - Total count hitting block multiple records pending monitor cell.
// - Insertion limited by leaky bucket grant and, on ingress, empty slots.
// - End-to-end cell pending past half block plus a cell sets late warning.
// - Cell pending a whole block plus a cell sets overflow; one cell covers both.
// - Generated monitor cell CLP comes from the configured setting.
// - Two-bit block size selects 128, 256, 512 or 1024 cells.
// - Block error detection code is 16-bit interleaved parity.
// - On insertion, sequence number is placed then incremented.
// - On insertion, block parity is placed then cleared.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module oam_loopback_and_block_monitor (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [oam_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Loopback cell classification, one cell per strobe
    input  wire logic                          lb_valid,
    input  wire logic                          lb_ingress,
    input  wire logic [7:0]                    lb_indication,
    input  wire logic [oam_pkg::LOCAL_NODE_IDENTIFIER_W-1:0] lb_location_id,
    input  wire logic [oam_pkg::LOCAL_NODE_IDENTIFIER_W-1:0] lb_source_id,
    output logic                               lb_remove,
    output logic                               lb_copy,
    output logic                               lb_done,
    // Transmit-side cells of the monitored connection
    input  wire logic                          tx_cell_valid,
    input  wire logic                          tx_cell_user,
    input  wire logic                          tx_cell_excluded,
    input  wire logic                          tx_cell_clp,
    input  wire logic                          tx_cell_sw_fmc,
    input  wire logic [oam_pkg::BIP_W-1:0]     tx_cell_bip,
    input  wire logic                          insert_grant,
    input  wire logic                          ingress_empty_slot,
    output logic                               fmc_insert,
    output logic      [oam_pkg::SN_W-1:0]      fmc_seq,
    output logic      [oam_pkg::CNT_W-1:0]     fmc_tuc,
    output logic      [oam_pkg::CNT_W-1:0]     fmc_tuc0,
    output logic      [oam_pkg::BIP_W-1:0]     fmc_bip,
    output logic                               fmc_clp,
    output logic                               e2e_monitor_late_warning,
    output logic                               monitor_cell_overflow_flag,
    // Receive-side cells of the reverse direction
    input  wire logic                          rx_cell_valid,
    input  wire logic                          rx_cell_user,
    input  wire logic                          rx_cell_clp,
    input  wire logic                          rx_cell_is_fmc,
    input  wire logic [oam_pkg::BIP_W-1:0]     rx_cell_bip,
    output logic                               rx_report_valid,
    output logic      [7:0]                    rx_block_error_result,
    output logic      [oam_pkg::CNT_W-1:0]     rx_total_count,
    output logic      [oam_pkg::CNT_W-1:0]     rx_clp0_count
);
    import oam_pkg::*;

    logic [31:0]          ctrl_q;
    logic [LOCAL_NODE_IDENTIFIER_W-1:0] local_node_identifier_q;
    logic [31:0]          perf_monitor_exclusion_reg_q;
    logic                 late_q;
    logic                 ovf_q;
    logic                 pending_q;
    logic [SN_W-1:0]      seq_q;
    logic [CNT_W-1:0]     tuc_q;
    logic [CNT_W-1:0]     tuc0_q;
    logic [BIP_W-1:0]     bip_q;
    logic [CNT_W-1:0]     since_boundary_q;
    logic [BIP_W-1:0]     rx_bip_q;
    logic [CNT_W-1:0]     rx_tot_q;
    logic [CNT_W-1:0]     rx_clp0_q;

    // APB decode; zero wait states, unmapped addresses answer an error
    wire apb_access = psel & penable;
    wire apb_setup  = psel & ~penable;
    wire apb_wr     = apb_access & pwrite;
    wire hit_ctrl   = (paddr == ADDR_CTRL);
    wire hit_node   = (paddr == ADDR_LOCAL_NODE_IDENTIFIER);
    wire hit_excl   = (paddr == ADDR_EXCL);
    wire hit_status = (paddr == ADDR_STATUS);
    wire hit_seq    = (paddr == ADDR_SEQ);
    wire hit_tuc    = (paddr == ADDR_TUC);
    wire hit_bip    = (paddr == ADDR_BIP);
    wire hit_rx     = (paddr == ADDR_RX_CNT);
    wire hit_any    = hit_ctrl | hit_node | hit_excl | hit_status | hit_seq | hit_tuc | hit_bip | hit_rx;

    assign pready  = 1'b1;
    assign pslverr = apb_access & ~hit_any;

    wire [31:0] status_word = {29'h0000_0000, pending_q, ovf_q, late_q};
    wire [31:0] rd_mux = hit_ctrl   ? ctrl_q :
                         hit_node   ? local_node_identifier_q :
                         hit_excl   ? perf_monitor_exclusion_reg_q :
                         hit_status ? status_word :
                         hit_seq    ? {24'h00_0000, seq_q} :
                         hit_tuc    ? {tuc0_q, tuc_q} :
                         hit_bip    ? {16'h0000, bip_q} :
                         hit_rx     ? {rx_clp0_q, rx_tot_q} : 32'h0000_0000;

    // Configuration fields
    wire            test_running = ctrl_q[CTRL_TR];
    wire            term_point   = ctrl_q[CTRL_TERM];
    wire            e2e_test     = ctrl_q[CTRL_E2E];
    wire [BLK_W-1:0] blk_sel     = ctrl_q[CTRL_BLK_LO +: BLK_W];
    wire            gen_egress   = ctrl_q[CTRL_GEN_EGR];

    wire [CNT_W-1:0] blk_len  = CNT_W'(1) << (BLK_MIN_LOG2 + int'(blk_sel));
    wire [CNT_W-1:0] blk_mask = blk_len - CNT_W'(1);
    wire [CNT_W-1:0] blk_half = blk_len >> 1;

    // indication layout check; malformed cells treated as not looped
    wire lb_ind_ok  = (lb_indication[7:1] == LB_UPPER_ZERO);
    wire lb_forward = lb_ind_ok & lb_indication[0];
    wire lb_back    = lb_ind_ok & ~lb_indication[0];
    wire loc_match  = (lb_location_id == local_node_identifier_q) |
                      ((lb_location_id == ALL_ONES_ID) & term_point);
    wire src_match  = lb_ingress & (lb_source_id == local_node_identifier_q);
    wire src_ones   = (lb_source_id == ALL_ONES_ID);
    wire act_r03    = lb_forward & loc_match;
    wire copy_r05   = lb_back & src_ones;
    // returned cells stop at the endpoint
    wire rem_r06    = lb_back & term_point;
    wire lb_rem_d   = act_r03 | (lb_back & src_match) | rem_r06;
    wire lb_cpy_d   = act_r03 | (lb_back & src_match) | copy_r05;

    wire tx_count   = tx_cell_valid & test_running & tx_cell_user & ~tx_cell_excluded;
    wire [CNT_W-1:0] tuc_next = tuc_q + CNT_W'(1);
    wire at_boundary = tx_count & ((tuc_next & blk_mask) == CNT_W'(0));
    wire opportunity = insert_grant & (gen_egress | ingress_empty_slot);
    wire do_insert   = pending_q & opportunity & test_running;
    wire late_hit    = tx_count & pending_q & e2e_test & (since_boundary_q >= blk_half);
    // whole block passed while still pending
    wire ovf_hit     = tx_count & pending_q & (since_boundary_q >= blk_len);

    wire [BIP_W-1:0] bip_diff = rx_bip_q ^ rx_cell_bip;
    logic [7:0] err_cnt;
    always_comb begin
        err_cnt = 8'h00;
        for (int i = 0; i < BIP_W; i++) begin
            err_cnt = err_cnt + {7'h00, bip_diff[i]};
        end
    end
    // checking runs on the reverse flow
    wire rx_count = rx_cell_valid & test_running & rx_cell_user;
    wire rx_fmc   = rx_cell_valid & test_running & rx_cell_is_fmc;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q                       <= CTRL_RESET;
            local_node_identifier_q      <= LOCAL_NODE_IDENTIFIER_RESET;
            perf_monitor_exclusion_reg_q <= 32'h0000_0000;
            prdata                       <= 32'h0000_0000;
        end else begin
            // first software monitor cell starts the test
            if (tx_cell_valid & tx_cell_sw_fmc)
                ctrl_q[CTRL_TR] <= 1'b1;
            // software stop; hardware start wins when simultaneous
            if (apb_wr & hit_ctrl)
                ctrl_q <= pwdata | {31'h0, tx_cell_valid & tx_cell_sw_fmc};
            if (apb_wr & hit_node)
                local_node_identifier_q <= pwdata;
            if (apb_wr & hit_excl)
                perf_monitor_exclusion_reg_q <= pwdata;
            // Snapshot at setup so the word already stands during the access phase
            if (apb_setup & ~pwrite)
                prdata <= rd_mux;
        end
    end

    // Late and overflow flags: write one to clear, a new event in the same cycle wins
    wire clr_late = apb_wr & hit_status & pwdata[ST_LATE];
    wire clr_ovf  = apb_wr & hit_status & pwdata[ST_OVF];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            late_q <= 1'b0;
            ovf_q  <= 1'b0;
        end else begin
            late_q <= late_hit | (late_q & ~clr_late);
            ovf_q  <= ovf_hit | (ovf_q & ~clr_ovf);
        end
    end
    assign e2e_monitor_late_warning   = late_q;
    assign monitor_cell_overflow_flag = ovf_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_q        <= 1'b0;
            seq_q            <= '0;
            tuc_q            <= '0;
            tuc0_q           <= '0;
            bip_q            <= '0;
            since_boundary_q <= '0;
        end else begin
            if (tx_count) begin
                tuc_q <= tuc_next;
                if (!tx_cell_clp)
                    tuc0_q <= tuc0_q + CNT_W'(1);
            end
            // even interleaved parity, cleared on insertion
            if (do_insert)
                bip_q <= tx_count ? tx_cell_bip : '0;
            else if (tx_count)
                bip_q <= bip_q ^ tx_cell_bip;
            if (do_insert)
                seq_q <= seq_q + SN_W'(1);
            // pending set at boundary, cleared at insertion; set wins
            if (at_boundary)
                pending_q <= 1'b1;
            else if (do_insert | ~test_running)
                pending_q <= 1'b0;
            // Age of pending request; restarts whenever a fresh request opens
            if (at_boundary & (~pending_q | do_insert))
                since_boundary_q <= '0;
            else if (tx_count & pending_q)
                since_boundary_q <= since_boundary_q + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmc_insert <= 1'b0;
            fmc_seq    <= '0;
            fmc_tuc    <= '0;
            fmc_tuc0   <= '0;
            fmc_bip    <= '0;
            fmc_clp    <= 1'b0;
        end else begin
            fmc_insert <= do_insert;
            if (do_insert) begin
                fmc_seq  <= seq_q;
                fmc_tuc  <= tuc_q;
                fmc_tuc0 <= tuc0_q;
                fmc_bip  <= bip_q;
                fmc_clp  <= ctrl_q[CTRL_CLP];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lb_remove <= 1'b0;
            lb_copy   <= 1'b0;
            lb_done   <= 1'b0;
        end else begin
            lb_done   <= lb_valid;
            lb_remove <= lb_valid & lb_rem_d;
            lb_copy   <= lb_valid & lb_cpy_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_bip_q              <= '0;
            rx_tot_q              <= '0;
            rx_clp0_q             <= '0;
            rx_report_valid       <= 1'b0;
            rx_block_error_result <= 8'h00;
            rx_total_count        <= '0;
            rx_clp0_count         <= '0;
        end else begin
            rx_report_valid <= rx_fmc;
            if (rx_count) begin
                rx_tot_q <= rx_tot_q + CNT_W'(1);
                if (!rx_cell_clp)
                    rx_clp0_q <= rx_clp0_q + CNT_W'(1);
            end
            if (rx_fmc) begin
                // errored parity bits of the block
                rx_block_error_result <= err_cnt;
                rx_total_count        <= rx_tot_q;
                rx_clp0_count         <= rx_clp0_q;
                rx_bip_q              <= '0;
            end else if (rx_count) begin
                rx_bip_q <= rx_bip_q ^ rx_cell_bip;
            end
        end
    end

    // sequence steps by one per inserted cell
    a_seq_step: assert property (@(posedge pclk) disable iff (!presetn)
        do_insert |=> seq_q == $past(seq_q) + SN_W'(1)) else $error("sequence did not step");
    a_bip_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (do_insert & ~tx_count) |=> bip_q == '0) else $error("parity not cleared");
    a_fmc_seq: assert property (@(posedge pclk) disable iff (!presetn)
        do_insert |=> fmc_insert && fmc_seq == $past(seq_q)) else $error("wrong inserted sequence");
    a_lb_fwd: assert property (@(posedge pclk) disable iff (!presetn)
        (lb_valid & lb_forward & loc_match) |=> lb_remove && lb_copy) else $error("loopback not taken");
    a_lb_src_ones: assert property (@(posedge pclk) disable iff (!presetn)
        (lb_valid & lb_back & src_ones) |=> lb_copy) else $error("unknown source not copied");
    a_lb_end_rem: assert property (@(posedge pclk) disable iff (!presetn)
        (lb_valid & lb_back & term_point) |=> lb_remove) else $error("endpoint did not remove");
    a_lb_ones_mid: assert property (@(posedge pclk) disable iff (!presetn)
        (lb_valid & lb_forward & ~term_point & (lb_location_id == ALL_ONES_ID)
         & (local_node_identifier_q != ALL_ONES_ID)) |=> !lb_remove) else $error("mid point took endpoint cell");
    a_stop_count: assert property (@(posedge pclk) disable iff (!presetn)
        !test_running |=> tuc_q == $past(tuc_q)) else $error("counted while stopped");
    a_pend_set: assert property (@(posedge pclk) disable iff (!presetn)
        at_boundary |=> pending_q) else $error("pending not set");
    a_ovf_set: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_hit |=> monitor_cell_overflow_flag) else $error("overflow not flagged");
endmodule : oam_loopback_and_block_monitor
`default_nettype wire

// ===== tb/cell_flow_model.sv
`timescale 1ns/10ps
`default_nettype none
module cell_flow_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic stall,
    input  wire logic slow,
    output logic      insert_grant,
    output logic      ingress_empty_slot
);
    logic [1:0] phase_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // bucket and slots
    // Slow mode grants one cycle in four, so a pending cell must wait its turn
    assign insert_grant       = !stall && (!slow || phase_q == 2'h3);
    assign ingress_empty_slot = !stall && phase_q[0];
endmodule : cell_flow_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import oam_pkg::*;
    localparam logic [31:0] NODE  = 32'h5A3C_0F12;
    localparam logic [31:0] OTHER = 32'h0000_0001;
    logic                 pclk;
    logic                 presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, stall = 1'h0, slow = 1'h0;
    logic [ADDR_W-1:0]    paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0, prdata, rd;
    logic                 pready, pslverr, err, lb_remove, lb_copy, lb_done, insert_grant, ingress_empty_slot;
    logic                 lb_valid = 1'h0, lb_ingress = 1'h0, tx_cell_valid = 1'h0, tx_cell_user = 1'h0;
    logic                 tx_cell_excluded = 1'h0, tx_cell_clp = 1'h0, tx_cell_sw_fmc = 1'h0, running = 1'h0;
    logic                 rx_cell_valid = 1'h0, rx_cell_user = 1'h0, rx_cell_clp = 1'h0, rx_cell_is_fmc = 1'h0;
    logic [7:0]           lb_indication = 8'h00, rx_block_error_result;
    logic [LOCAL_NODE_IDENTIFIER_W-1:0] lb_location_id = 32'h0, lb_source_id = 32'h0;
    logic [BIP_W-1:0]     tx_cell_bip = 16'h0, rx_cell_bip = 16'h0, exp_bip = 16'h0, rx_bip = 16'h0, fmc_bip;
    logic [CNT_W-1:0]     exp_tuc = 16'h0, exp_tuc0 = 16'h0, fmc_tuc, fmc_tuc0, rx_total_count, rx_clp0_count;
    logic [SN_W-1:0]      fmc_seq;
    logic                 fmc_insert, fmc_clp, e2e_monitor_late_warning, monitor_cell_overflow_flag, rx_report_valid;
    int                   fails = 0, compares = 0, n_ins = 0, i;

    oam_loopback_and_block_monitor i_oam_loopback_and_block_monitor (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .lb_valid, .lb_ingress, .lb_indication, .lb_location_id, .lb_source_id, .lb_remove, .lb_copy, .lb_done,
        .tx_cell_valid, .tx_cell_user, .tx_cell_excluded, .tx_cell_clp, .tx_cell_sw_fmc, .tx_cell_bip,
        .insert_grant, .ingress_empty_slot, .fmc_insert, .fmc_seq, .fmc_tuc, .fmc_tuc0, .fmc_bip, .fmc_clp,
        .e2e_monitor_late_warning, .monitor_cell_overflow_flag, .rx_cell_valid, .rx_cell_user, .rx_cell_clp,
        .rx_cell_is_fmc, .rx_cell_bip, .rx_report_valid, .rx_block_error_result, .rx_total_count, .rx_clp0_count
    );

    cell_flow_model i_cell_flow_model (
        .pclk, .presetn, .stall, .slow, .insert_grant, .ingress_empty_slot
    );

    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (fmc_insert === 1'h1) begin
            n_ins <= n_ins + 1;
        end
    end

    task automatic end_sim();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // Read data stands in the access phase and is taken at the completing edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        err = pslverr;
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic lb(input logic ing, input logic [7:0] ind, input logic [31:0] loc, input logic [31:0] src,
                      input logic xr, input logic xc);
        @(posedge pclk);
        lb_valid <= 1'h1;
        lb_ingress <= ing;
        lb_indication <= ind;
        lb_location_id <= loc;
        lb_source_id <= src;
        @(posedge pclk);
        lb_valid <= 1'h0;
        #1;
        `CHK({lb_done, lb_remove, lb_copy}, {1'h1, xr, xc})
    endtask : lb

    task automatic tx(input logic u, input logic x, input logic c, input logic s, input logic [15:0] b);
        @(posedge pclk);
        tx_cell_valid <= 1'h1;
        tx_cell_user <= u;
        tx_cell_excluded <= x;
        tx_cell_clp <= c;
        tx_cell_sw_fmc <= s;
        tx_cell_bip <= b;
        @(posedge pclk);
        tx_cell_valid <= 1'h0;
        if (running && u && !x) begin
            exp_tuc = exp_tuc + 16'h1;
            exp_tuc0 = exp_tuc0 + {15'h0, !c};
            exp_bip = exp_bip ^ b;
        end
    endtask : tx

    task automatic users(input int n);
        for (int k = 0; k < n; k++) begin
            tx(1'h1, 1'h0, k[0], 1'h0, 16'h1357 ^ exp_tuc);
        end
    endtask : users

    task automatic rx(input logic u, input logic c, input logic f, input logic [15:0] b);
        @(posedge pclk);
        rx_cell_valid <= 1'h1;
        rx_cell_user <= u;
        rx_cell_clp <= c;
        rx_cell_is_fmc <= f;
        rx_cell_bip <= b;
        @(posedge pclk);
        rx_cell_valid <= 1'h0;
        #1;
    endtask : rx

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, ADDR_CTRL, 32'h0);
        `CHK(rd, CTRL_RESET)
        apb(1'h0, ADDR_LOCAL_NODE_IDENTIFIER, 32'h0);
        `CHK(rd, LOCAL_NODE_IDENTIFIER_RESET)
        apb(1'h0, 12'h0FC, 32'h0);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1'h1, ADDR_LOCAL_NODE_IDENTIFIER, NODE);
        lb(1'h1, 8'h01, NODE, OTHER, 1'h1, 1'h1); // location match
        lb(1'h1, 8'h01, OTHER, OTHER, 1'h0, 1'h0); // no match
        lb(1'h1, 8'h01, ALL_ONES_ID, OTHER, 1'h0, 1'h0); // not terminating
        lb(1'h1, 8'h00, OTHER, NODE, 1'h1, 1'h1); // source match
        lb(1'h0, 8'h00, OTHER, NODE, 1'h0, 1'h0); // egress ignored
        lb(1'h1, 8'h00, OTHER, ALL_ONES_ID, 1'h0, 1'h1); // copy only
        lb(1'h1, 8'h00, OTHER, OTHER, 1'h0, 1'h0); // intermediate
        lb(1'h1, 8'h81, NODE, OTHER, 1'h0, 1'h0); // malformed
        apb(1'h1, ADDR_CTRL, 32'h2);
        lb(1'h1, 8'h01, ALL_ONES_ID, OTHER, 1'h1, 1'h1); // endpoint match
        lb(1'h0, 8'h00, OTHER, ALL_ONES_ID, 1'h1, 1'h1); // endpoint
        lb(1'h0, 8'h00, OTHER, OTHER, 1'h1, 1'h0); // endpoint removal
        lb(1'h1, 8'h80, OTHER, OTHER, 1'h0, 1'h0); // malformed
        apb(1'h1, ADDR_CTRL, 32'h0000_000C);
        stall <= 1'h1;
        tx(1'h0, 1'h0, 1'h0, 1'h1, 16'h0);
        running = 1'h1;
        apb(1'h0, ADDR_CTRL, 32'h0);
        `CHK(rd[CTRL_TR], 1'h1) // test started
        tx(1'h1, 1'h1, 1'h0, 1'h0, 16'hFFFF);
        users(128);
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK(rd[ST_PEND:ST_LATE], 3'h4) // pending
        apb(1'h0, ADDR_TUC, 32'h0);
        `CHK(rd, {exp_tuc0, exp_tuc}) // counts
        users(63);
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK(rd[ST_PEND:ST_LATE], 3'h4) // not yet late
        users(2);
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK({rd[ST_PEND:ST_LATE], e2e_monitor_late_warning}, 4'hB) // late warning
        users(62);
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK(rd[ST_PEND:ST_LATE], 3'h5) // no overflow yet
        users(2);
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK({rd[ST_PEND:ST_LATE], monitor_cell_overflow_flag}, 4'hF) // overflow
        stall <= 1'h0;
        slow <= 1'h1;
        i = 0;
        do begin @(posedge pclk); #1; end while (fmc_insert !== 1'h1 && i++ < 100);
        `CHK({fmc_insert, fmc_seq, fmc_tuc, fmc_tuc0, fmc_bip, fmc_clp}, {1'h1, 8'h00, exp_tuc, exp_tuc0, exp_bip, 1'h1})
        exp_bip = 16'h0;
        repeat (20) @(posedge pclk);
        `CHK(n_ins, 1) // one cell
        apb(1'h0, ADDR_SEQ, 32'h0);
        `CHK(rd[7:0], 8'h01) // incremented
        apb(1'h0, ADDR_BIP, 32'h0);
        `CHK(rd[15:0], 16'h0) // cleared
        apb(1'h1, ADDR_STATUS, 32'h3);
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK(rd[ST_PEND:ST_LATE], 3'h0) // pending cleared
        for (i = 0; i < 5; i++) begin
            rx(1'h1, i[0], 1'h0, 16'h0F0F << i);
            rx_bip = rx_bip ^ (16'h0F0F << i);
        end
        rx(1'h0, 1'h0, 1'h1, rx_bip ^ 16'h0013);
        `CHK({rx_report_valid, rx_block_error_result, rx_total_count, rx_clp0_count}, {1'h1, 8'h03, 16'h5, 16'h3})
        apb(1'h1, ADDR_CTRL, 32'h0000_000C);
        running = 1'h0;
        users(3);
        apb(1'h0, ADDR_TUC, 32'h0);
        `CHK(rd, {exp_tuc0, exp_tuc}) // counting stopped
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
